// >>> hdl/pstr_status_telemetry.v
/*
 Status and telemetry readback: the communication/memory/logic fault
 byte, the vendor status byte (latched per-channel and global faults plus
 live handshake bits), and the input and output voltage readback words.
 Assumes the command decoder, ADC, servo, sequencer and fault-pin logic
 run on sys_clk and deliver one-cycle event pulses; only the two shared
 fault-line pins arrive asynchronously.
 Reads are single-cycle requests from the command front end; the answer
 is registered and held until the next request, so a slow host can take
 it late. Flags are cleared only by clear_faults or by the per-channel
 restart pulses; nothing on the read port writes them.
 Converter words arrive already formatted; this block only stores them,
 together with the format flag of each output word; the input word always reads as linear.
 The alert output is a plain registered level, active low.
*/
`timescale 1ns/1ns
`include "pstr_consts.vh"

module pstr_status_telemetry (
    // Clock, reset and the asynchronous fault-line pins
    input wire sys_clk,
    input wire rst_n,
    input wire shared_fault_line_0_n,
    input wire shared_fault_line_1_n,
    // Communication fault events and the clear pulse
    input wire illegal_cmd_event,
    input wire illegal_data_event,
    input wire pec_error_event,
    input wire nvm_fault_event,
    input wire other_comm_event,
    input wire clear_faults,
    // Per-channel events and live levels
    input wire [7:0] discharge_fault_event,
    input wire [7:0] turn_on_attempt,
    input wire [7:0] fault_line0_event,
    input wire [7:0] fault_line1_event,
    input wire [7:0] run_pin_toggle,
    input wire [7:0] operation_on_off,
    input wire [7:0] servo_target_reached,
    input wire [7:0] trim_dac_connected,
    input wire [7:0] servo_end_saturated,
    // Global conditions and converter results
    input wire vin_en_faulted_off,
    input wire watchdog_timeout,
    input wire vin_conv_valid,
    input wire [15:0] vin_conv_data,
    input wire vout_conv_valid,
    input wire [2:0] vout_conv_ch,
    input wire [15:0] vout_conv_data,
    input wire [7:0] current_sense_mode,
    // Read port and status outputs
    input wire rd_req,
    input wire [2:0] rd_sel,
    input wire [2:0] rd_page,
    output reg [15:0] rd_data,
    output reg rd_valid,
    output reg rd_linear11,
    output reg cml_summary,
    output reg alert_out_n
);

    // Fault-line pins come from other devices; two flops before any use.
    // Both reset high so a released reset never looks like a pulled line,
    // at the price of two cycles of blindness after each line change
    reg [1:0] fl_meta;
    reg [1:0] fl_sync;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_meta <= 2'h3;
            fl_sync <= 2'h3;
        end else begin
            fl_meta <= {shared_fault_line_1_n, shared_fault_line_0_n};
            fl_sync <= fl_meta;
        end
    end

    // Sticky flag update: a new event beats a clear landing in the same
    // cycle, so a fault raised during the clear is never lost
    function sticky;
        input set;
        input held;
        input clr;
        begin
            sticky = set | (held & ~clr);
        end
    endfunction

    // Sticky communication/memory/logic flags; a new event beats a clear
    reg cml_cmd;
    reg cml_data;
    reg cml_pec;
    reg cml_mem;
    reg cml_other;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cml_cmd <= 1'b0;
            cml_data <= 1'b0;
            cml_pec <= 1'b0;
            cml_mem <= 1'b0;
            cml_other <= 1'b0;
        end else begin
            cml_cmd <= sticky(illegal_cmd_event, cml_cmd, clear_faults);
            cml_data <= sticky(illegal_data_event, cml_data, clear_faults);
            cml_pec <= sticky(pec_error_event, cml_pec, clear_faults);
            cml_mem <= sticky(nvm_fault_event, cml_mem, clear_faults);
            cml_other <= sticky(other_comm_event, cml_other, clear_faults);
        end
    end

    // Per-channel latched vendor faults, one copy per page; every page
    // keeps its own history, so switching pages never loses a fault
    wire [7:0] lat_disch;
    wire [7:0] lat_fl0;
    wire [7:0] lat_fl1;
    wire [7:0] lat_sat;
    genvar g;
    generate
        for (g = 0; g < `PSTR_NCH; g = g + 1) begin : g_ch
            // One latch per vendor fault field of this channel
            reg disch;
            reg fl0;
            reg fl1;
            reg sat;
            // Fault-line history also restarts on a run toggle or on/off cycle
            wire fl_clr = clear_faults | run_pin_toggle[g] | operation_on_off[g];
            wire set0 = fault_line0_event[g] | (turn_on_attempt[g] & ~fl_sync[0]);
            wire set1 = fault_line1_event[g] | (turn_on_attempt[g] & ~fl_sync[1]);
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    disch <= 1'b0;
                    fl0 <= 1'b0;
                    fl1 <= 1'b0;
                    sat <= 1'b0;
                end else begin
                    disch <= sticky(discharge_fault_event[g], disch, clear_faults);
                    fl0 <= sticky(set0, fl0, fl_clr);
                    fl1 <= sticky(set1, fl1, fl_clr);
                    sat <= sticky(servo_end_saturated[g], sat, clear_faults);
                end
            end
            assign lat_disch[g] = disch;
            assign lat_fl0[g] = fl0;
            assign lat_fl1[g] = fl1;
            assign lat_sat[g] = sat;
        end
    endgenerate

    // Global watchdog latch, seen from every page; only clear_faults
    // drops it, a page's restart pulses leave it alone
    reg wdog;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog <= 1'b0;
        end else begin
            wdog <= sticky(watchdog_timeout, wdog, clear_faults);
        end
    end

    // Telemetry words; the converter supplies each word already formatted,
    // so this block stores and returns them without any arithmetic
    reg [15:0] vin_word;
    reg [15:0] vout_mem [0:7];
    reg [7:0] vout_lin11;
    integer i;

    // Input reading: the latest conversion wins
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vin_word <= `PSTR_ZERO16;
        end else if (vin_conv_valid) begin
            vin_word <= vin_conv_data;
        end
    end

    // Output readings per channel, with the format flag taken at store
    // time; a mode change only affects conversions that follow it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vout_lin11 <= `PSTR_ZERO8;
            for (i = 0; i < `PSTR_NCH; i = i + 1) begin
                vout_mem[i] <= `PSTR_ZERO16;
            end
        end else if (vout_conv_valid) begin
            vout_mem[vout_conv_ch] <= vout_conv_data;
            // Only odd channels can measure current; even ones stay unsigned
            vout_lin11[vout_conv_ch] <= vout_conv_ch[0] &
                                        current_sense_mode[vout_conv_ch];
        end
    end

    // Selected page's bit of a per-channel vector; used for every
    // per-page field of the vendor byte, so that byte's page decode lives in one place
    function page_bit;
        input [7:0] vec;
        input [2:0] page;
        begin
            page_bit = vec[page];
        end
    endfunction

    // Communication/memory/logic byte; unimplemented positions stay zero
    reg [7:0] cml_byte;
    always @* begin
        cml_byte = `PSTR_ZERO8;
        cml_byte[`PSTR_CML_CMD] = cml_cmd;
        cml_byte[`PSTR_CML_DATA] = cml_data;
        cml_byte[`PSTR_CML_PEC] = cml_pec;
        cml_byte[`PSTR_CML_MEM] = cml_mem;
        cml_byte[`PSTR_CML_OTHER] = cml_other;
    end

    // Vendor byte for the selected page; live bits are sampled as read,
    // so a host polling them sees the condition of that very cycle
    reg [7:0] mfr_byte;
    always @* begin
        mfr_byte = `PSTR_ZERO8;
        mfr_byte[`PSTR_MFR_DISCH] = page_bit(lat_disch, rd_page);
        mfr_byte[`PSTR_MFR_FL1] = page_bit(lat_fl1, rd_page);
        mfr_byte[`PSTR_MFR_FL0] = page_bit(lat_fl0, rd_page);
        mfr_byte[`PSTR_MFR_SERVO] = page_bit(servo_target_reached, rd_page);
        mfr_byte[`PSTR_MFR_DAC] = page_bit(trim_dac_connected, rd_page);
        mfr_byte[`PSTR_MFR_SAT] = page_bit(lat_sat, rd_page);
        // Global bits ignore the page
        mfr_byte[`PSTR_MFR_VINEN] = vin_en_faulted_off;
        mfr_byte[`PSTR_MFR_WDOG] = wdog;
    end

    // Next answer, chosen at the request edge; without a request the
    // previous word is held so the host may sample it late
    reg [15:0] next_rd_data;
    reg next_rd_linear11;
    always @* begin
        next_rd_data = rd_data;
        next_rd_linear11 = rd_linear11;
        if (rd_req) begin
            next_rd_linear11 = 1'b0;
            case (rd_sel)
                `PSTR_SEL_CML: begin
                    next_rd_data = {`PSTR_ZERO8, cml_byte};
                end
                `PSTR_SEL_MFR: begin
                    next_rd_data = {`PSTR_ZERO8, mfr_byte};
                end
                `PSTR_SEL_VIN: begin
                    next_rd_data = vin_word;
                    next_rd_linear11 = 1'b1;
                end
                `PSTR_SEL_VOUT: begin
                    next_rd_data = vout_mem[rd_page];
                    next_rd_linear11 = vout_lin11[rd_page];
                end
                `PSTR_SEL_VMODE: begin
                    next_rd_data = {11'h000, `PSTR_VOUT_EXP};
                end
                // Unused selects read as zero rather than stale data
                default: begin
                    next_rd_data = `PSTR_ZERO16;
                end
            endcase
        end
    end

    // Read port registers: answer one cycle after the request
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `PSTR_ZERO16;
            rd_valid <= 1'b0;
            rd_linear11 <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            rd_data <= next_rd_data;
            rd_linear11 <= next_rd_linear11;
        end
    end

    // Alert sources; live handshake bits never reach the alert, and the
    // alert rises again only once every latch below has been cleared
    wire any_cml = cml_cmd | cml_data | cml_pec | cml_mem | cml_other;
    wire any_vendor = (|lat_disch) | (|lat_fl0) | (|lat_fl1) | (|lat_sat) | wdog;
    wire any_latched = any_cml | any_vendor;

    // Alert and summary flops; one cycle behind the flags, a lag that a
    // host reading right after an event must allow for
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_out_n <= 1'b1;
            cml_summary <= 1'b0;
        end else begin
            alert_out_n <= ~any_latched;
            cml_summary <= any_cml;
        end
    end

endmodule // pstr_status_telemetry

// >>> hdl/pstr_consts.vh
/*
 Constants for the status and telemetry readback block: read selects,
 bit positions of the status bytes, channel count and the fixed output
 voltage exponent. Assumes it is included by bare name from design files.
*/
`ifndef PSTR_CONSTS_VH
`define PSTR_CONSTS_VH

`define PSTR_NCH 8
`define PSTR_CHW 3

// Read selects
`define PSTR_SEL_CML 3'h0
`define PSTR_SEL_MFR 3'h1
`define PSTR_SEL_VIN 3'h2
`define PSTR_SEL_VOUT 3'h3
`define PSTR_SEL_VMODE 3'h4

// Communication/memory/logic status byte
`define PSTR_CML_CMD 7
`define PSTR_CML_DATA 6
`define PSTR_CML_PEC 5
`define PSTR_CML_MEM 4
`define PSTR_CML_OTHER 1

// Vendor status byte
`define PSTR_MFR_DISCH 7
`define PSTR_MFR_FL1 6
`define PSTR_MFR_FL0 5
`define PSTR_MFR_SERVO 4
`define PSTR_MFR_DAC 3
`define PSTR_MFR_SAT 2
`define PSTR_MFR_VINEN 1
`define PSTR_MFR_WDOG 0

// Output voltage exponent, -13 as 5-bit two's complement
`define PSTR_VOUT_EXP 5'h13
`define PSTR_ZERO8 8'h00
`define PSTR_ZERO16 16'h0000

`endif

// >>> verif/pstr_assertions.sv
/* Port checker for the readback block.
   Assumes the bench binds it onto the block. */
`timescale 1ns/1ns
module pstr_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire illegal_cmd_event,
    input wire pec_error_event,
    input wire watchdog_timeout,
    input wire rd_req,
    input wire [2:0] rd_sel,
    input wire [2:0] rd_page,
    input wire [15:0] rd_data,
    input wire rd_valid,
    input wire rd_linear11,
    input wire cml_summary,
    input wire alert_out_n
);
    // One clock domain, so one default clocking and reset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    read_pulse_a: assert property (rd_valid == $past(rd_req))
        else $error("read answer misplaced");
    cmd_fault_a: assert property (illegal_cmd_event |-> ##2 cml_summary && !alert_out_n)
        else $error("command fault not flagged");
    pec_summary_a: assert property (pec_error_event |-> ##2 cml_summary)
        else $error("checking fault not summarised");
    watchdog_alert_a: assert property (watchdog_timeout |-> ##2 !alert_out_n)
        else $error("watchdog not alerting");
    cml_zero_a: assert property (rd_req && rd_sel == 3'h0 |=> rd_data[3:2] == 2'h0 && !rd_data[0])
        else $error("unused status bits set");
    vout_exp_a: assert property (rd_req && rd_sel == 3'h4 |=> rd_data == 16'h0013)
        else $error("wrong output exponent");
    vin_linear_a: assert property (rd_req && rd_sel == 3'h2 |=> rd_linear11)
        else $error("input word not linear");
    even_plain_a: assert property (rd_req && rd_sel == 3'h3 && !rd_page[0] |=> !rd_linear11)
        else $error("even channel read as linear");
endmodule // pstr_chk

// >>> verif/pstr_host.sv
/* Host model: issues one-cycle reads and takes the answer.
   Assumes the answer comes one edge after the request. */
`timescale 1ns/1ns
module pstr_host (
    input wire sys_clk,
    input wire rd_valid,
    input wire [15:0] rd_data,
    output logic rd_req = 1'b0,
    output logic [2:0] rd_sel = 3'h0,
    output logic [2:0] rd_page = 3'h0
);
    // A missing answer comes back unknown so the compare fails
    task rd(input logic [2:0] sel, input logic [2:0] pg, output logic [15:0] d);
        @(posedge sys_clk) #1;
        rd_req = 1'b1;
        rd_sel = sel;
        rd_page = pg;
        @(posedge sys_clk) #1;
        rd_req = 1'b0;
        d = rd_valid ? rd_data : 16'hXXXX;
    endtask
endmodule // pstr_host

// >>> verif/pstr_status_telemetry_tb.sv
/* Bench for the readback block with host model and bound checker.
   Assumes design, checker and host files compile first. */
`timescale 1ns/1ns
module pstr_status_telemetry_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, clear_faults = 1'b0, watchdog_timeout = 1'b0;
    logic shared_fault_line_0_n = 1'b1, shared_fault_line_1_n = 1'b1, vin_en_faulted_off = 1'b0;
    logic vin_conv_valid = 1'b0, vout_conv_valid = 1'b0;
    logic [2:0] vout_conv_ch = 3'h0, ch;
    logic [4:0] cml_ev = 5'h00;
    logic [15:0] vin_conv_data = 16'h0000, vout_conv_data = 16'h0000, d;
    logic [7:0] discharge_fault_event = 8'h00, turn_on_attempt = 8'h00, seed = 8'h04;
    logic [7:0] fault_line0_event = 8'h00, fault_line1_event = 8'h00, run_pin_toggle = 8'h00;
    logic [7:0] operation_on_off = 8'h00, servo_target_reached = 8'h00, trim_dac_connected = 8'h00;
    logic [7:0] servo_end_saturated = 8'h00, current_sense_mode = 8'h00;
    wire rd_req, rd_valid, rd_linear11, cml_summary, alert_out_n;
    wire [2:0] rd_sel, rd_page;
    wire [15:0] rd_data;
    int miscompares = 0, checked = 0, cycles = 0;
    int cb[5] = '{7, 6, 5, 4, 1}, vb[4] = '{7, 2, 5, 6};
    pstr_status_telemetry dut_u (.*, .illegal_cmd_event(cml_ev[4]), .illegal_data_event(cml_ev[3]),
        .pec_error_event(cml_ev[2]), .nvm_fault_event(cml_ev[1]), .other_comm_event(cml_ev[0]));
    pstr_host host_u (.*);
    // Clock, and a ceiling well above the expected run of about 155 cycles
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize;
        end
    end
    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function logic [15:0] lin(input logic [2:0] c);
        return {15'h0000, c[0] & current_sense_mode[c]};
    endfunction
    task tick; @(posedge sys_clk) #1; endtask
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task clear;
        tick;
        clear_faults = 1'b1;
        tick;
        clear_faults = 1'b0;
    endtask
    task summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Fault codes, latched vendor bits, live bits, then the readback words
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            tick;
            cml_ev = 5'h10 >> i;
            tick;
            cml_ev = 5'h00;
            host_u.rd(3'h0, 3'h0, d);
            chk("cml byte", d, 16'h0001 << cb[i]);
            chk("summary", {15'h0000, cml_summary}, 16'h0001);
            chk("cml alert", {15'h0000, alert_out_n}, 16'h0000);
            clear;
            repeat (3) tick;
            chk("alert free", {15'h0000, alert_out_n}, 16'h0001);
            chk("summary free", {15'h0000, cml_summary}, 16'h0000);
        end
        $display("test cml done");
        shared_fault_line_1_n = 1'b0;
        for (int k = 0; k < 4; k++) begin
            ch = seed[2:0];
            seed = lfsr(seed);
            tick;
            discharge_fault_event = 8'(k == 0) << ch;
            servo_end_saturated = 8'(k == 1) << ch;
            fault_line0_event = 8'(k == 2) << ch;
            turn_on_attempt = 8'(k == 3) << ch;
            tick;
            {discharge_fault_event, servo_end_saturated, fault_line0_event, turn_on_attempt} = 32'h0;
            host_u.rd(3'h1, ch, d);
            chk("own page", d, 16'h0001 << vb[k]);
            host_u.rd(3'h1, ch ^ 3'h1, d);
            chk("other page", d, 16'h0000);
            chk("alert set", {15'h0000, alert_out_n}, 16'h0000);
            tick;
            clear_faults = k < 2;
            operation_on_off = 8'(k == 2) << ch;
            run_pin_toggle = 8'(k == 3) << ch;
            tick;
            {clear_faults, operation_on_off, run_pin_toggle} = 17'h0;
            host_u.rd(3'h1, ch, d);
            chk("cleared", d, 16'h0000);
            repeat (2) tick;
            chk("alert free", {15'h0000, alert_out_n}, 16'h0001);
        end
        shared_fault_line_1_n = 1'b1;
        watchdog_timeout = 1'b1;
        tick;
        watchdog_timeout = 1'b0;
        host_u.rd(3'h1, seed[5:3], d);
        chk("watchdog", d, 16'h0001);
        clear;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            ch = seed[2:0];
            servo_target_reached = seed;
            trim_dac_connected = lfsr(seed);
            vin_en_faulted_off = seed[3];
            host_u.rd(3'h1, ch, d);
            chk("live", d, {11'h000, seed[ch], trim_dac_connected[ch], 1'b0, seed[3], 1'b0});
            chk("alert idle", {15'h0000, alert_out_n}, 16'h0001);
        end
        $display("test vendor done");
        vin_conv_data = {seed, lfsr(seed)};
        vin_conv_valid = 1'b1;
        tick;
        vin_conv_valid = 1'b0;
        host_u.rd(3'h2, 3'h0, d);
        chk("vin", d, vin_conv_data);
        current_sense_mode = lfsr(seed);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            vout_conv_ch = 3'(i);
            vout_conv_data = {seed, 8'hA5};
            vout_conv_valid = 1'b1;
            tick;
            vout_conv_valid = 1'b0;
            host_u.rd(3'h3, 3'(i), d);
            chk("vout", d, vout_conv_data);
            chk("linear", {15'h0000, rd_linear11}, lin(3'(i)));
        end
        host_u.rd(3'h4, 3'h0, d);
        chk("exponent", d, 16'h0013);
        $display("test readback done");
        summarize;
    end
endmodule // pstr_status_telemetry_tb

bind pstr_status_telemetry pstr_chk chk_u (.*);
